// file: rtl/rcr_params.svh
// Constants of the reset cause recorder: offsets, field positions, reset values, timing
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

// ==========================================
// Register offsets (byte addresses)
`define RCR_CAUSE_OFS     8'h00
`define RCR_STAT_OFS      8'h04
`define RCR_MASK_OFS      8'h08
`define RCR_SWRST_OFS     8'h0C

// ==========================================
// Field positions
`define RCR_HVD_BIT       29
`define RCR_CMR_BIT       9
`define RCR_VREG_BIT      8
`define RCR_EXT_BIT       7
`define RCR_SWR_BIT       6
`define RCR_WDT_BIT       4
`define RCR_SLEEP_BIT     3
`define RCR_IDLE_BIT      2
`define RCR_BOR_BIT       1
`define RCR_POR_BIT       0
`define RCR_SWRST_GO_BIT  0

// ==========================================
// Reset values and implemented bits
`define RCR_CAUSE_RESET   32'h0000_0003
`define RCR_IMPL_MASK     32'h2000_03DF

// ==========================================
// Timing
`define RCR_CLK_PERIOD_NS 100
`define RCR_HOLD_NS       1000
`define RCR_HOLD_CYCLES   ((`RCR_HOLD_NS + `RCR_CLK_PERIOD_NS - 1) / `RCR_CLK_PERIOD_NS)

`endif

// file: rtl/rcr_pkg.sv
// Types shared by the reset cause recorder modules
package rcr_pkg;
	typedef logic [31:0] rcr_word_t;
	typedef logic [7:0] rcr_adr_t;
	typedef logic [3:0] rcr_sel_t;
	typedef enum logic {RCR_HOLD_ASSERT, RCR_HOLD_RELEASED} rcr_hold_state_t;
endpackage

// file: rtl/rcr_flag_if.sv
// Carrier between the recorder core and one sticky flag
`timescale 1ns/100ps
`default_nettype none
interface rcr_flag_if;
	logic set;
	logic wr_en;
	logic wr_val;
	logic q;
	modport ctl  (output set, output wr_en, output wr_val, input q);
	modport flag (input set, input wr_en, input wr_val, output q);
endinterface
`default_nettype wire

// file: rtl/rcr_event_flag.sv
// One sticky flag: hardware set wins over a software write
`timescale 1ns/100ps
`default_nettype none
module rcr_event_flag #(
	parameter bit RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Flag carrier
	rcr_flag_if.flag fl
);
	import rcr_pkg::*;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fl.q <= RESET_VAL;
		end else if (ce) begin
			fl.q <= fl.set | (fl.wr_en ? fl.wr_val : fl.q);
		end
	end

	set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && fl.set |=> fl.q)
		else $error("flag lost an event");
	flag_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!fl.set && !(ce && fl.wr_en) |=> fl.q == $past(fl.q))
		else $error("flag changed without cause");
endmodule
`default_nettype wire

// file: rtl/rcr_reset_hold.sv
// Stretches merged reset requests into the master system reset
`timescale 1ns/100ps
`default_nettype none
`include "rcr_params.svh"
module rcr_reset_hold #(
	parameter int unsigned HOLD_CYCLES = `RCR_HOLD_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Request and reset out
	input wire logic req,
	output logic     sys_reset
);
	import rcr_pkg::*;

	localparam int CW = $clog2(HOLD_CYCLES + 1);
	localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_CYCLES);

	generate
		if (HOLD_CYCLES < 1) begin : g_bad
			$error("HOLD_CYCLES must be at least 1");
		end
	endgenerate

	rcr_hold_state_t state;
	rcr_hold_state_t next_state;
	logic [CW-1:0]   cnt;
	logic [CW-1:0]   next_cnt;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			RCR_HOLD_ASSERT: begin
				if (req) begin
					next_cnt = HOLD_LOAD;
				end else if (cnt <= 1) begin
					next_state = RCR_HOLD_RELEASED;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			RCR_HOLD_RELEASED: begin
				if (req) begin
					next_state = RCR_HOLD_ASSERT;
					next_cnt = HOLD_LOAD;
				end
			end
			default: begin
				next_state = RCR_HOLD_ASSERT;
				next_cnt = HOLD_LOAD;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= RCR_HOLD_ASSERT;
			cnt <= HOLD_LOAD;
			sys_reset <= 1'b1;
		end else if (ce) begin
			state <= next_state;
			cnt <= next_cnt;
			sys_reset <= (next_state == RCR_HOLD_ASSERT);
		end
	end
endmodule
`default_nettype wire

// file: rtl/rcr_recorder.sv
// Reset cause recorder: merges reset sources, records causes, Wishbone slave
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rcr_params.svh"

module rcr_recorder #(
	parameter int unsigned HOLD_CYCLES = `RCR_HOLD_CYCLES
) (
	// Clock, reset, enable
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        ce,
	// Wishbone slave
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire rcr_pkg::rcr_adr_t  wb_adr_i,
	input wire rcr_pkg::rcr_sel_t  wb_sel_i,
	input wire rcr_pkg::rcr_word_t wb_dat_i,
	output rcr_pkg::rcr_word_t     wb_dat_o,
	output logic            wb_ack_o,
	// Reset and wake sources
	input wire logic        master_clear_pin_n,
	input wire logic        watchdog_reset_source,
	input wire logic        brown_out_req,
	input wire logic        config_mismatch_req,
	input wire logic        high_voltage_req,
	input wire logic        wake_from_sleep,
	input wire logic        wake_from_idle,
	// Outputs
	output logic            master_system_reset,
	output logic            regulator_sleep_keep_on,
	output logic            irq
);
	import rcr_pkg::*;

	// ==========================================
	// Parameter check
	generate
		if (HOLD_CYCLES < 1) begin : g_bad_hold
			$error("HOLD_CYCLES must be at least 1");
		end
	endgenerate

	// ==========================================
	// Flag layout
	// Bit 8 of the cause word is the regulator control, so it has no flag here
	localparam int NFLAG = 9;
	localparam int FLAG_POS [NFLAG] = '{
		`RCR_HVD_BIT, `RCR_CMR_BIT, `RCR_EXT_BIT,
		`RCR_SWR_BIT, `RCR_WDT_BIT, `RCR_SLEEP_BIT,
		`RCR_IDLE_BIT, `RCR_BOR_BIT, `RCR_POR_BIT
	};
	localparam rcr_word_t CAUSE_RST = `RCR_CAUSE_RESET;
	localparam rcr_word_t IMPL_MASK = `RCR_IMPL_MASK;
	localparam logic [5:0] CAUSE_IDX = 6'(`RCR_CAUSE_OFS >> 2);
	localparam logic [5:0] STAT_IDX = 6'(`RCR_STAT_OFS >> 2);
	localparam logic [5:0] MASK_IDX = 6'(`RCR_MASK_OFS >> 2);
	localparam logic [5:0] SWRST_IDX = 6'(`RCR_SWRST_OFS >> 2);

	logic [NFLAG-1:0] flag_evt;
	logic [NFLAG-1:0] cause_q;
	logic [NFLAG-1:0] stat_q;
	logic [NFLAG-1:0] mask_q;
	rcr_word_t        wmask;
	rcr_word_t        cause_word;
	rcr_word_t        stat_word;
	rcr_word_t        mask_word;
	rcr_word_t        rd_word;
	logic             bus_req;
	logic             wr_go;
	logic             wr_cause;
	logic             wr_stat;
	logic             wr_mask;
	logic             wr_swrst;
	logic             swr_pulse;
	logic             any_req;
	logic [5:0]       adr_idx;

	// ==========================================
	// Bus decode
	assign adr_idx = wb_adr_i[7:2];
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land on the edge at which the master sees ack
	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign wr_cause = wr_go & (adr_idx == CAUSE_IDX);
	assign wr_stat = wr_go & (adr_idx == STAT_IDX);
	assign wr_mask = wr_go & (adr_idx == MASK_IDX);
	assign wr_swrst = wr_go & (adr_idx == SWRST_IDX);
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// ==========================================
	// Event sources, index order follows FLAG_POS
	assign flag_evt = {
		1'b0,                  // power-on is the block reset itself
		brown_out_req,
		wake_from_idle,
		wake_from_sleep,
		watchdog_reset_source,
		swr_pulse,
		~master_clear_pin_n,
		config_mismatch_req,
		high_voltage_req
	};

	// ==========================================
	// Cause flags and interrupt status flags
	for (genvar i = 0; i < NFLAG; i++) begin : g_flag
		rcr_flag_if cause_if ();
		rcr_flag_if stat_if ();

		assign cause_if.set = flag_evt[i];
		assign cause_if.wr_en = wr_cause & wmask[FLAG_POS[i]];
		assign cause_if.wr_val = wb_dat_i[FLAG_POS[i]];
		assign stat_if.set = flag_evt[i];
		assign stat_if.wr_en = wr_stat & wmask[FLAG_POS[i]] & wb_dat_i[FLAG_POS[i]];
		assign stat_if.wr_val = 1'b0;
		assign cause_q[i] = cause_if.q;
		assign stat_q[i] = stat_if.q;

		rcr_event_flag #(
			.RESET_VAL (CAUSE_RST[FLAG_POS[i]])
		) u_cause (
			.clk_sys (clk_sys),
			.rst_n   (rst_n),
			.ce      (ce),
			.fl      (cause_if.flag)
		);

		rcr_event_flag #(
			.RESET_VAL (CAUSE_RST[FLAG_POS[i]])
		) u_stat (
			.clk_sys (clk_sys),
			.rst_n   (rst_n),
			.ce      (ce),
			.fl      (stat_if.flag)
		);
	end

	// ==========================================
	// Register words; unimplemented bits stay zero
	always_comb begin
		cause_word = '0;
		stat_word = '0;
		mask_word = '0;
		for (int i = 0; i < NFLAG; i++) begin
			cause_word[FLAG_POS[i]] = cause_q[i];
			stat_word[FLAG_POS[i]] = stat_q[i];
			mask_word[FLAG_POS[i]] = mask_q[i];
		end
		cause_word[`RCR_VREG_BIT] = regulator_sleep_keep_on;
	end

	always_comb begin
		case (adr_idx)
			CAUSE_IDX: begin
				rd_word = cause_word & IMPL_MASK;
			end
			STAT_IDX: begin
				rd_word = stat_word;
			end
			MASK_IDX: begin
				rd_word = mask_word;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// ==========================================
	// Bus answer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else if (ce) begin
			wb_ack_o <= bus_req;
		end
	end

	// Read data is taken at the request edge and stands while ack is high
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= '0;
		end else if (ce && bus_req) begin
			wb_dat_o <= wb_we_i ? '0 : rd_word;
		end
	end

	// ==========================================
	// Regulator control and interrupt mask
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regulator_sleep_keep_on <= CAUSE_RST[`RCR_VREG_BIT];
		end else if (ce && wr_cause && wmask[`RCR_VREG_BIT]) begin
			regulator_sleep_keep_on <= wb_dat_i[`RCR_VREG_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= '0;
		end else if (ce && wr_mask) begin
			for (int i = 0; i < NFLAG; i++) begin
				if (wmask[FLAG_POS[i]]) begin
					mask_q[i] <= wb_dat_i[FLAG_POS[i]];
				end
			end
		end
	end

	// Level interrupt, one cycle behind the status and mask registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(stat_q & mask_q);
		end
	end

	// ==========================================
	// Software reset request and reset merge
	// Waits one cycle so that the bus answer completes before the reset rises
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			swr_pulse <= 1'b0;
		end else if (ce) begin
			swr_pulse <= wr_swrst & wb_sel_i[0] & wb_dat_i[`RCR_SWRST_GO_BIT];
		end
	end

	assign any_req = ~master_clear_pin_n | swr_pulse | watchdog_reset_source
		| brown_out_req | config_mismatch_req | high_voltage_req;

	rcr_reset_hold #(
		.HOLD_CYCLES (HOLD_CYCLES)
	) u_hold (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.ce        (ce),
		.req       (any_req),
		.sys_reset (master_system_reset)
	);

	// ==========================================
	// Checks
	// High only at the first edge after power-on reset
	logic first_cyc;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			first_cyc <= 1'b1;
		end else begin
			first_cyc <= 1'b0;
		end
	end

	merge_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && any_req |=> master_system_reset)
		else $error("reset request did not assert master reset");
	hvd_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && high_voltage_req |=> cause_word[`RCR_HVD_BIT])
		else $error("high voltage flag not set");
	cmr_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && config_mismatch_req |=> cause_word[`RCR_CMR_BIT])
		else $error("mismatch flag not set");
	vreg_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && wr_cause && wb_sel_i[1]
		|=> regulator_sleep_keep_on == $past(wb_dat_i[`RCR_VREG_BIT]))
		else $error("regulator bit not written");
	ext_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !master_clear_pin_n |=> cause_word[`RCR_EXT_BIT] && master_system_reset)
		else $error("pin reset not recorded");
	swr_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && wr_swrst && wb_sel_i[0] && wb_dat_i[0] ##1 ce
		|=> cause_word[`RCR_SWR_BIT] && master_system_reset)
		else $error("software reset not recorded");
	wdt_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && watchdog_reset_source |=> cause_word[`RCR_WDT_BIT])
		else $error("watchdog flag not set");
	wake_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && (wake_from_sleep || wake_from_idle) |=> (cause_word[3:2]
		& $past({wake_from_sleep, wake_from_idle})) == $past({wake_from_sleep, wake_from_idle}))
		else $error("wake flag not set");
	por_value_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		first_cyc |-> cause_word[1:0] == 2'b11 && master_system_reset)
		else $error("power-on flags wrong after reset");
	unimpl_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wb_ack_o && !wb_we_i && adr_idx == CAUSE_IDX |-> (wb_dat_o & ~IMPL_MASK) == '0)
		else $error("unimplemented bits read nonzero");
	ack_once_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && bus_req |=> wb_ack_o)
		else $error("request not answered");
	bor_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && brown_out_req |=> cause_word[`RCR_BOR_BIT])
		else $error("brown-out flag not set");
	flag_no_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !wr_cause |=> ($past(cause_q) & ~cause_q) == '0)
		else $error("cause flag cleared without a write");
	por_no_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !wr_cause |=> $past(cause_word[`RCR_POR_BIT]) || !cause_word[`RCR_POR_BIT])
		else $error("power-on flag set without power-on reset");
	vreg_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !(wr_cause && wmask[`RCR_VREG_BIT]) |=> $stable(regulator_sleep_keep_on))
		else $error("regulator bit changed without a write");
	stat_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && wr_stat && flag_evt == '0
		|=> (stat_word & $past(wmask & wb_dat_i)) == '0)
		else $error("status bit not cleared by write of one");
	irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce |=> irq == $past(|(stat_q & mask_q)))
		else $error("interrupt level wrong");

	// Main scenarios
	pin_reset_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		!master_clear_pin_n ##1 master_system_reset);
	sw_reset_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		swr_pulse ##1 master_system_reset);
	irq_raise_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		!irq ##1 irq);
	wdt_reset_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		watchdog_reset_source ##1 master_system_reset);
	irq_clear_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		irq ##1 !irq);
endmodule
`default_nettype wire

// file: tb/rcr_src_model.sv
// Model of the reset and wake sources around the recorder
`timescale 1ns/100ps
`default_nettype none
module rcr_src_model (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Stimulus, one bit per source
	input  wire logic [6:0] fire,
	// Source lines
	output logic            master_clear_pin_n,
	output logic            watchdog_reset_source,
	output logic            brown_out_req,
	output logic            config_mismatch_req,
	output logic            high_voltage_req,
	output logic            wake_from_sleep,
	output logic            wake_from_idle
);
	logic [6:0] act;
	logic [6:0] act_d;
	logic [6:0] line;

	// ==========================================
	// Request timing
	// Each request stands two edges, so the recorder sees a level, not a glitch
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			act   <= 7'h00;
			act_d <= 7'h00;
		end else begin
			act   <= fire;
			act_d <= act;
		end
	end

	assign line                  = act | act_d;
	assign master_clear_pin_n    = ~line[0];
	assign watchdog_reset_source = line[1];
	assign brown_out_req         = line[2];
	assign config_mismatch_req   = line[3];
	assign high_voltage_req      = line[4];
	assign wake_from_sleep       = line[5];
	assign wake_from_idle        = line[6];
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the reset cause recorder
`timescale 1ns/100ps
`default_nettype none
`include "rcr_params.svh"
module tb_top;
	import rcr_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst_n   = 1'b0;
	logic       wb_cyc  = 1'b0;
	logic       wb_stb  = 1'b0;
	logic       wb_we   = 1'b0;
	rcr_adr_t   wb_adr  = 8'h00;
	rcr_sel_t   wb_sel  = 4'h0;
	rcr_word_t  wb_dat  = 32'h0000_0000;
	rcr_word_t  wb_rdat;
	logic       wb_ack;
	logic [6:0] fire    = 7'h00;
	logic       ce      = 1'b1;
	logic       pin_n, wdt, bor, config_mismatch_flag, hvd, wk_sleep, wk_idle;
	logic       sys_rst, reg_keep, irq;
	int         n_mismatch  = 0;
	int         check_count = 0;

	always #50 clk_sys = ~clk_sys;

	// ==========================================
	// Design and source model
	rcr_recorder #(.HOLD_CYCLES(2)) u_rcr_recorder (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.master_clear_pin_n(pin_n), .watchdog_reset_source(wdt), .brown_out_req(bor),
		.config_mismatch_req(config_mismatch_flag), .high_voltage_req(hvd), .wake_from_sleep(wk_sleep),
		.wake_from_idle(wk_idle), .master_system_reset(sys_rst),
		.regulator_sleep_keep_on(reg_keep), .irq(irq)
	);
	rcr_src_model u_rcr_src_model (
		.clk_sys(clk_sys), .rst_n(rst_n), .fire(fire), .master_clear_pin_n(pin_n),
		.watchdog_reset_source(wdt), .brown_out_req(bor), .config_mismatch_req(config_mismatch_flag),
		.high_voltage_req(hvd), .wake_from_sleep(wk_sleep), .wake_from_idle(wk_idle)
	);

	// ==========================================
	// Shared tasks
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input rcr_word_t seen, input rcr_word_t exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One classic Wishbone cycle; data is taken at the edge where ack is seen
	task automatic wb_xfer(input logic we, input rcr_adr_t a, input rcr_sel_t s,
			input rcr_word_t d, output rcr_word_t q);
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= a;
		wb_sel <= s;
		wb_dat <= d;
		do begin
			@(posedge clk_sys);
		end while (wb_ack !== 1'b1);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
	endtask

	task automatic wait_reset_end();
		int n;
		n = 0;
		while (sys_rst !== 1'b0 && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		chk("reset_end", {31'h0, sys_rst}, 32'h0);
	endtask

	task automatic fire_src(input int idx);
		@(posedge clk_sys);
		fire <= 7'h01 << idx;
		@(posedge clk_sys);
		fire <= 7'h00;
		repeat (2) @(posedge clk_sys);
	endtask

	// ==========================================
	// Scenarios
	task automatic scn_reset();
		rcr_word_t q;
		@(posedge clk_sys);
		chk("reset_out", {31'h0, sys_rst}, 32'h1);
		wb_xfer(1'b0, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		chk("cause_por", q, 32'h0000_0003);
		chk("reg_keep", {31'h0, reg_keep}, 32'h0);
		wait_reset_end();
	endtask

	// Flags gather over several resets: earlier ones must survive later ones
	task automatic scn_sources();
		int        bitpos [7] = '{7, 4, 1, 9, 29, 3, 2};
		rcr_word_t exp;
		rcr_word_t q;
		exp = 32'h0;
		wb_xfer(1'b1, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		for (int i = 0; i < 7; i++) begin
			fire_src(i);
			chk("src_reset", {31'h0, sys_rst}, {31'h0, i < 5});
			wait_reset_end();
			exp[bitpos[i]] = 1'b1;
			wb_xfer(1'b0, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
			chk("cause_src", q, exp);
		end
		wb_xfer(1'b1, `RCR_SWRST_OFS, 4'h1, 32'h1, q);
		repeat (3) @(posedge clk_sys);
		chk("sw_reset", {31'h0, sys_rst}, 32'h1);
		wait_reset_end();
		wb_xfer(1'b0, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		chk("cause_sw", q, exp | 32'h0000_0040);
	endtask

	task automatic scn_rw();
		rcr_word_t q;
		wb_xfer(1'b1, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		wb_xfer(1'b1, `RCR_CAUSE_OFS, 4'h2, 32'hFFFF_FFFF, q);
		wb_xfer(1'b0, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		chk("lane1", q, 32'h0000_0300);
		@(posedge clk_sys);
		chk("reg_keep_on", {31'h0, reg_keep}, 32'h1);
		wb_xfer(1'b1, `RCR_CAUSE_OFS, 4'hF, 32'hFFFF_FFFF, q);
		wb_xfer(1'b0, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		chk("all_ones", q, 32'h2000_03DF);
		wb_xfer(1'b1, 8'h10, 4'hF, 32'h0, q);
		wb_xfer(1'b0, 8'h10, 4'hF, 32'h0, q);
		chk("unmapped", q, 32'h0);
		wb_xfer(1'b0, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		chk("unmapped_wr", q, 32'h2000_03DF);
		wb_xfer(1'b1, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		wb_xfer(1'b0, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		chk("cleared", q, 32'h0);
		@(posedge clk_sys);
		chk("reg_keep_off", {31'h0, reg_keep}, 32'h0);
	endtask

	task automatic scn_irq();
		rcr_word_t q;
		wb_xfer(1'b1, `RCR_MASK_OFS, 4'hF, 32'h0000_0010, q);
		wb_xfer(1'b1, `RCR_STAT_OFS, 4'hF, 32'hFFFF_FFFF, q);
		repeat (2) @(posedge clk_sys);
		chk("irq_idle", {31'h0, irq}, 32'h0);
		fire_src(1);
		wait_reset_end();
		chk("irq_set", {31'h0, irq}, 32'h1);
		wb_xfer(1'b0, `RCR_STAT_OFS, 4'hF, 32'h0, q);
		chk("status", q, 32'h0000_0010);
		wb_xfer(1'b1, `RCR_STAT_OFS, 4'hF, 32'h0000_0010, q);
		repeat (2) @(posedge clk_sys);
		chk("irq_clear", {31'h0, irq}, 32'h0);
		wb_xfer(1'b1, `RCR_MASK_OFS, 4'hF, 32'h0, q);
		fire_src(3);
		wait_reset_end();
		chk("irq_masked", {31'h0, irq}, 32'h0);
		wb_xfer(1'b0, `RCR_STAT_OFS, 4'hF, 32'h0, q);
		chk("status_m", q, 32'h0000_0200);
	endtask

	// With the enable low the recorder ignores even a reset request
	task automatic scn_freeze();
		rcr_word_t q;
		wb_xfer(1'b1, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		ce <= 1'b0;
		fire_src(1);
		repeat (2) @(posedge clk_sys);
		chk("frz_reset", {31'h0, sys_rst}, 32'h0);
		ce <= 1'b1;
		wb_xfer(1'b0, `RCR_CAUSE_OFS, 4'hF, 32'h0, q);
		chk("frz_cause", q, 32'h0);
		chk("frz_reset_after", {31'h0, sys_rst}, 32'h0);
	endtask

	// ==========================================
	// Main sequence and watchdog
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		scn_reset();
		scn_sources();
		scn_rw();
		scn_irq();
		scn_freeze();
		report_and_stop();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		report_and_stop();
	end
endmodule
`default_nettype wire
